// >>> dv/scp_command_port_props.sv
`timescale 1ns/100ps
module scp_command_port_props (
    input wire       sys_clk,               // block clock
    input wire       reset_n,               // synchronous reset, active low
    input wire       spi_cs_n,              // chip select pin
    input wire       spi_sdo_oe_n,          // sdo enable, low active
    input wire [7:0] mode_supply_control,   // control 0x01
    input wire [7:0] transceiver_control_a, // control 0x04
    input wire [7:0] system_scratch_status, // control 0x1E
    input wire [5:0] mode_state,            // one-hot mode
    input wire       soft_reset,            // soft reset pulse
    input wire       watchdog_trigger       // trigger pulse
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_sdo_release: assert property (spi_cs_n [*5] |-> spi_sdo_oe_n)
        else $error("sdo still driven after select rise");
    a_sdo_drive: assert property (!spi_cs_n [*5] |-> !spi_sdo_oe_n)
        else $error("sdo not driven inside frame");
    a_mode_onehot: assert property ($onehot(mode_state))
        else $error("mode state not one-hot");
    a_soft_init: assert property (soft_reset |-> ##[0:2]
        (mode_state == 6'h01 && system_scratch_status == 8'h00))
        else $error("soft reset did not restore init");
    a_pulse_single: assert property (soft_reset || watchdog_trigger |=>
        !soft_reset && !watchdog_trigger)
        else $error("pulse longer than one cycle");
    a_sleep_xcvr: assert property ($rose(mode_state[3]) |-> ##[0:1]
        (transceiver_control_a[1:0] != 2'h3 && transceiver_control_a[4:3] != 2'h3
        && mode_supply_control[7:6] == 2'h1))
        else $error("sleep entry left transceiver on");
    a_normal_field: assert property ($rose(mode_state[1]) |-> ##[0:1]
        mode_supply_control[7:6] == 2'h0)
        else $error("mode field not normal");
    a_sleep_quiet: assert property (mode_state[3] && $past(mode_state[3]) |->
        $stable(system_scratch_status))
        else $error("register changed in sleep");
    a_aux_normal: assert property ($changed(mode_supply_control[4:3]) &&
        mode_supply_control[4:3] != 2'h0 |-> $past(mode_state[1]))
        else $error("aux supply set outside normal");
    c_sleep: cover property ($rose(mode_state[3]));
    c_stop: cover property ($rose(mode_state[2]));
    c_soft: cover property (soft_reset);
endmodule // scp_command_port_props
bind scp_command_port scp_command_port_props i_scp_command_port_props (
    .sys_clk, .reset_n, .spi_cs_n, .spi_sdo_oe_n, .mode_supply_control,
    .transceiver_control_a, .system_scratch_status, .mode_state, .soft_reset,
    .watchdog_trigger
);

// >>> dv/scp_command_port_tb.sv
`timescale 1ns/100ps
module scp_command_port_tb;
    logic       sys_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       wake_input = 1'b0;
    logic [3:0] ev = 4'h0;  // wake, restart done, fail-safe entry, exit
    logic [7:0] st [8] = '{default: 8'h00};
    wire        spi_cs_n, spi_clk, spi_sdi, spi_sdo_out, spi_sdo_oe_n;
    wire  [7:0] mode_supply_control, transceiver_control_a, system_scratch_status;
    wire  [5:0] mode_state;
    int         error_cnt = 0;
    int         check_count = 0;
    always #2.5 sys_clk = ~sys_clk;
    scp_command_port i_scp_command_port (
        .sys_clk, .reset_n, .spi_cs_n, .spi_clk, .spi_sdi, .wake_input,
        .supply_status_set(st[0]), .thermal_status_set(st[1]), .device_status_set(st[2]),
        .transceiver_status_a_set(st[3]), .transceiver_status_b_set(st[4]),
        .wake_event_status_a_set(st[5]), .wake_event_status_b_set(st[6]),
        .regulator_status_set(st[7]), .wake_event(ev[0]), .restart_done(ev[1]),
        .failsafe_event(ev[2]), .failsafe_exit(ev[3]), .spi_sdo_out, .spi_sdo_oe_n,
        .mode_supply_control, .hardware_config(), .watchdog_control(),
        .transceiver_control_a, .transceiver_control_b(), .wake_source_control_a(),
        .wake_source_control_b(), .wake_pin_pull_control(), .cyclic_timer_control(),
        .system_scratch_status, .mode_state, .soft_reset(), .watchdog_trigger()
    );
    scp_spi_master i_scp_spi_master (
        .spi_cs_n, .spi_clk, .spi_sdi, .spi_sdo_out, .spi_sdo_oe_n
    );
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic [15:0] c, input logic [7:0] d);
        i_scp_spi_master.frame(c, 16);
        chk("data byte", {8'h00, d}, {8'h00, i_scp_spi_master.rx[16:9]});
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic pulse(input int b, input logic [5:0] m);
        @(negedge sys_clk) ev[b] = 1'b1;
        @(negedge sys_clk) ev[b] = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("mode", {10'h000, m}, {10'h000, mode_state});
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (5) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("mode", 16'h0001, {10'h000, mode_state});
        xfer(16'hA59E, 8'h00);
        xfer(16'h001E, 8'hA5);
        xfer(16'h8081, 8'h00);
        chk("mode", 16'h0002, {10'h000, mode_state});
        xfer(16'h0043, 8'h02);
        chk("summary", 16'h0004, {8'h00, i_scp_spi_master.rx[8:1]});
        xfer(16'h00C3, 8'h02);
        xfer(16'h0043, 8'h00);
        i_scp_spi_master.frame(16'h009E, 8);
        i_scp_spi_master.frame(16'h0000, 0);
        chk("error bit", 16'h0001, {15'h0000, i_scp_spi_master.rx[0]});
        i_scp_spi_master.frame(16'h0000, 0);
        chk("error bit", 16'h0000, {15'h0000, i_scp_spi_master.rx[0]});
        xfer(16'h001E, 8'hA5);
        wake_input = 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(negedge sys_clk) st[i] = 8'h81;
            @(negedge sys_clk) st[i] = 8'h00;
            xfer({8'h00, 1'b1, i < 7 ? 7'h41 + 7'(i) : 7'h4C}, 8'h81);
            chk("summary", 16'h0001 << i, {8'h00, i_scp_spi_master.rx[8:1]});
        end
        xfer(16'h00C8, 8'h01);
        chk("summary", 16'h0000, {8'h00, i_scp_spi_master.rx[8:1]});
        xfer(16'h0048, 8'h01);
        xfer(16'h0384, 8'h00);
        xfer(16'h4081, 8'h00);
        chk("mode", 16'h0008, {10'h000, mode_state});
        chk("xcvr a", 16'h0001, {8'h00, transceiver_control_a});
        i_scp_spi_master.frame(16'h009E, 16);
        chk("scratch", 16'h00A5, {8'h00, system_scratch_status});
        pulse(0, 6'h10);
        pulse(1, 6'h02);
        xfer(16'h8081, 8'h00);
        chk("mode", 16'h0004, {10'h000, mode_state});
        xfer(16'h4081, 8'h80);
        chk("mode", 16'h0010, {10'h000, mode_state});
        pulse(1, 6'h02);
        xfer(16'h00C3, 8'h02);
        pulse(2, 6'h20);
        i_scp_spi_master.frame(16'h009E, 16);
        chk("scratch", 16'h00A5, {8'h00, system_scratch_status});
        pulse(3, 6'h10);
        pulse(1, 6'h02);
        xfer(16'hC081, 8'h00);
        chk("scratch", 16'h0000, {8'h00, system_scratch_status});
        chk("mode", 16'h0001, {10'h000, mode_state});
        xfer(16'h4081, 8'h00);
        chk("mode", 16'h0002, {10'h000, mode_state});
        xfer(16'h4081, 8'h00);
        chk("mode", 16'h0010, {10'h000, mode_state});
        pulse(1, 6'h02);
        xfer(16'h00C3, 8'h02);
        xfer(16'h0881, 8'h00);
        xfer(16'h8081, 8'h08);
        chk("mode", 16'h0004, {10'h000, mode_state});
        xfer(16'h0083, 8'h00);
        xfer(16'h0043, 8'h00);
        xfer(16'h8083, 8'h00);
        xfer(16'h0043, 8'h02);
        xfer(16'h0003, 8'h00);
        summarize();
    end
endmodule // scp_command_port_tb

// >>> dv/scp_spi_master.sv
`timescale 1ns/100ps
module scp_spi_master (
    output logic spi_cs_n,     // chip select to device
    output logic spi_clk,      // serial clock, still outside frames
    output logic spi_sdi,      // serial data to device
    input  wire  spi_sdo_out,  // serial data from device
    input  wire  spi_sdo_oe_n  // device drive enable, low active
);
    logic [16:0] rx;  // error bit, summary, data
    // released line reads the inverse, never a stale copy
    wire         line = spi_sdo_oe_n ? ~spi_sdo_out : spi_sdo_out;
    initial begin
        spi_cs_n = 1'b1;
        spi_clk = 1'b0;
        spi_sdi = 1'b0;
    end
    // data changes at rise, stable at fall
    task automatic frame(input logic [15:0] cmd, input int n);
        spi_cs_n = 1'b0;
        #40 rx = {16'h0000, line};
        for (int k = 0; k < n; k++) begin
            spi_clk = 1'b1;
            spi_sdi = cmd[k];
            #40 rx[k+1] = line;
            spi_clk = 1'b0;
            #40;
        end
        spi_cs_n = 1'b1;
        #40;
    endtask
endmodule // scp_spi_master

// >>> hw/scp_command_port.v
// Operation
// - sleep request in stop mode is invalid, ignored, device enters restart.
// - stop or sleep request in init mode is invalid, device enters normal.
// - in stop mode only trigger, normal, soft reset, stop, reads, clears pass.
// - sleep with transceiver a and wake b all zero fails, enters restart.
// - stop with all wake sources off is accepted without failure.
// - frame must carry 0 or 16 clocks, else word is discarded.
// - clock high at a chip select edge voids the command, flags error.
// - after a frame error, next frame shows error bit before first clock.
// - a zero-clock poll frame sets the error bit only if clock is high at a select edge.
// - command holds address in bits 6..0, access bit 7, data 15..8.
// - access bit: control read or write, status read or read-and-clear.
// - status bits are never cleared on their own; the control mode field follows every mode change.
// - commands are not interpreted in restart, sleep or fail-safe mode.
// - status access returns register contents in the same frame.
// - control access returns the pre-frame value; writes land at frame end.
// - each response carries an 8-bit summary, one bit per status register.
// - summary bits 0..6 map to 0x41..0x47, bit 7 to 0x4C.
// - wake level register shows live pin, not clearable, not summarised.
// - 0x01..0x1E decode as control, 0x41..0x7E as status registers.
// - mode field always follows the mode actually entered.
// - entering sleep turns transceivers that were on to wake capable.
// - auxiliary supply setting is written only in normal mode; soft reset clears it in init, normal or stop mode.
// - input sampled on falling clock edge, output shifted after rising edge.
// - word is acted on at chip select rise; output then released.
// - invalid command is ignored and sets a sticky fail flag.
// - mode request 00 normal, 01 sleep, 10 stop, 11 soft reset.
`timescale 1ns/100ps
`include "scp_defs.vh"
module scp_command_port (
    input  wire       sys_clk,                 // 200 MHz block clock
    input  wire       reset_n,                 // synchronous reset, active low
    input  wire       spi_cs_n,                // chip select pin, active low
    input  wire       spi_clk,                 // serial clock pin
    input  wire       spi_sdi,                 // serial data in pin
    input  wire       wake_input,              // wake pin level
    input  wire [7:0] supply_status_set,       // hardware set bits, 0x41
    input  wire [7:0] thermal_status_set,      // hardware set bits, 0x42
    input  wire [7:0] device_status_set,       // hardware set bits, 0x43
    input  wire [7:0] transceiver_status_a_set,// hardware set bits, 0x44
    input  wire [7:0] transceiver_status_b_set,// hardware set bits, 0x45
    input  wire [7:0] wake_event_status_a_set, // hardware set bits, 0x46
    input  wire [7:0] wake_event_status_b_set, // hardware set bits, 0x47
    input  wire [7:0] regulator_status_set,    // hardware set bits, 0x4C
    input  wire       wake_event,              // wake seen in sleep
    input  wire       restart_done,            // restart finished
    input  wire       failsafe_event,          // severe fault, go fail-safe
    input  wire       failsafe_exit,           // fail-safe wait over
    output reg        spi_sdo_out,             // serial data out level
    output wire       spi_sdo_oe_n,            // low while sdo is driven
    output wire [7:0] mode_supply_control,     // control 0x01
    output wire [7:0] hardware_config,         // control 0x02
    output wire [7:0] watchdog_control,        // control 0x03
    output wire [7:0] transceiver_control_a,   // control 0x04
    output wire [7:0] transceiver_control_b,   // control 0x05
    output wire [7:0] wake_source_control_a,   // control 0x06
    output wire [7:0] wake_source_control_b,   // control 0x07
    output wire [7:0] wake_pin_pull_control,   // control 0x08
    output wire [7:0] cyclic_timer_control,    // control 0x0C
    output wire [7:0] system_scratch_status,   // control 0x1E
    output reg  [5:0] mode_state,              // one-hot current mode
    output reg        soft_reset,              // one-cycle soft reset pulse
    output reg        watchdog_trigger         // one-cycle trigger pulse
);

    localparam [5:0] S_INIT     = 6'h01;
    localparam [5:0] S_NORMAL   = 6'h02;
    localparam [5:0] S_STOP     = 6'h04;
    localparam [5:0] S_SLEEP    = 6'h08;
    localparam [5:0] S_RESTART  = 6'h10;
    localparam [5:0] S_FAILSAFE = 6'h20;

    reg  [7:0] ctrl [0:9];
    reg  [7:0] stat [0:7];
    reg  [4:0] fcnt;
    reg  [4:0] rcnt;
    reg [15:0] rx;
    reg  [7:0] tx_sum;
    reg  [7:0] tx_dat;
    reg        lvl_err;
    reg        err_flag;
    reg        frame_active;
    reg        cs_d;
    reg        clk_d;
    reg  [5:0] next_mode;
    reg        ctrl_we;
    reg  [7:0] wdata;
    reg        fail;
    reg        do_soft;
    reg        do_trig;
    reg  [7:0] rd_val;
    reg  [7:0] summary;
    integer    i;

    wire [3:0] pins_s;
    wire [7:0] st_set [0:7];

    scp_sync #(
        .W(4)
    ) u_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in ({wake_input, spi_sdi, spi_clk, ~spi_cs_n}),
        .sync_out (pins_s)
    );

    // select goes through inverted so the reset value of the sync reads idle
    wire cs_s   = ~pins_s[0];
    wire clk_s  = pins_s[1];
    wire sdi_s  = pins_s[2];
    wire wake_s = pins_s[3];

    wire cs_fall  = cs_d & ~cs_s;
    wire cs_rise  = ~cs_d & cs_s;
    // edges only count inside a frame
    wire clk_rise = frame_active & ~cs_s & ~clk_d & clk_s;
    wire clk_fall = frame_active & ~cs_s & clk_d & ~clk_s;

    // clock level at both select edges
    wire frame_bad = lvl_err | clk_s | ((fcnt != 5'h00) && (fcnt != `SCP_FRAME_BITS));

    wire [6:0] cmd_addr = rx[6:0];
    wire       cmd_wr   = rx[7];
    wire [7:0] cmd_data = rx[15:8];

    wire listening = (mode_state == S_INIT) | (mode_state == S_NORMAL) |
                     (mode_state == S_STOP);
    wire cmd_go = cs_rise & ~frame_bad & (fcnt == `SCP_FRAME_BITS) & listening;

    assign st_set[0] = supply_status_set;
    assign st_set[1] = thermal_status_set;
    assign st_set[2] = device_status_set;
    assign st_set[3] = transceiver_status_a_set;
    assign st_set[4] = transceiver_status_b_set;
    assign st_set[5] = wake_event_status_a_set;
    assign st_set[6] = wake_event_status_b_set;
    assign st_set[7] = regulator_status_set;

    assign mode_supply_control   = ctrl[0];
    assign hardware_config       = ctrl[1];
    assign watchdog_control      = ctrl[2];
    assign transceiver_control_a = ctrl[3];
    assign transceiver_control_b = ctrl[4];
    assign wake_source_control_a = ctrl[5];
    assign wake_source_control_b = ctrl[6];
    assign wake_pin_pull_control = ctrl[7];
    assign cyclic_timer_control  = ctrl[8];
    assign system_scratch_status = ctrl[9];

    assign spi_sdo_oe_n = ~frame_active;

    function [4:0] sat_inc;
        input [4:0] v;
        begin
            sat_inc = (v == 5'h1F) ? v : v + 5'h01;
        end
    endfunction

    // control decode, bit 4 marks a miss
    function [4:0] ctrl_index;
        input [6:0] a;
        begin
            case (a)
                `SCP_ADDR_MODE_CTRL:  ctrl_index = 5'h00;
                `SCP_ADDR_HW_CFG:     ctrl_index = 5'h01;
                `SCP_ADDR_WDOG_CTRL:  ctrl_index = 5'h02;
                `SCP_ADDR_XCVR_A:     ctrl_index = 5'h03;
                `SCP_ADDR_XCVR_B:     ctrl_index = 5'h04;
                `SCP_ADDR_WAKE_A:     ctrl_index = 5'h05;
                `SCP_ADDR_WAKE_B:     ctrl_index = 5'h06;
                `SCP_ADDR_PULL_CTRL:  ctrl_index = 5'h07;
                `SCP_ADDR_TIMER_CTRL: ctrl_index = 5'h08;
                `SCP_ADDR_SCRATCH:    ctrl_index = 5'h09;
                default:              ctrl_index = 5'h10;
            endcase
        end
    endfunction

    // status decode, bit 3 marks a miss
    function [3:0] stat_index;
        input [6:0] a;
        begin
            case (a)
                `SCP_ADDR_SUP_STAT:   stat_index = 4'h0;
                `SCP_ADDR_THERMAL_STATUS: stat_index = 4'h1;
                `SCP_ADDR_DEVICE_STATUS:   stat_index = 4'h2;
                `SCP_ADDR_XST_A:      stat_index = 4'h3;
                `SCP_ADDR_XST_B:      stat_index = 4'h4;
                `SCP_ADDR_WST_A:      stat_index = 4'h5;
                `SCP_ADDR_WST_B:      stat_index = 4'h6;
                `SCP_ADDR_REG_STAT:   stat_index = 4'h7;
                default:              stat_index = 4'h8;
            endcase
        end
    endfunction

    function [1:0] mode_code;
        input [5:0] m;
        begin
            case (m)
                S_SLEEP: mode_code = `SCP_MODE_SLEEP;
                S_STOP:  mode_code = `SCP_MODE_STOP;
                default: mode_code = `SCP_MODE_NORMAL;
            endcase
        end
    endfunction

    function [7:0] xcvr_sleep;
        input [7:0] v;
        begin
            xcvr_sleep = v;
            if (v[1:0] == `SCP_XCVR_ON)
                xcvr_sleep[1:0] = `SCP_XCVR_WAKE;
            if (v[4:3] == `SCP_XCVR_ON)
                xcvr_sleep[4:3] = `SCP_XCVR_WAKE;
        end
    endfunction

    wire [4:0] cidx = ctrl_index(cmd_addr);
    wire [3:0] sidx = stat_index(cmd_addr);
    wire [4:0] ridx = ctrl_index(rx[6:0]);
    wire [3:0] rsidx = stat_index(rx[6:0]);

    // wake level kept out of summary
    always @* begin
        for (i = 0; i < 8; i = i + 1)
            summary[i] = |stat[i];
    end

    always @* begin
        rd_val = 8'h00;
        if (!ridx[4])
            rd_val = ctrl[ridx[3:0]];
        // status read in the same frame
        else if (!rsidx[3])
            rd_val = stat[rsidx[2:0]];
        else if (rx[6:0] == `SCP_ADDR_WAKE_LVL)
            rd_val = {7'h00, wake_s};
        else if (rx[6:0] == `SCP_ADDR_FAMILY_ID)
            rd_val = `SCP_FAMILY_ID_VAL;
    end

    // command decision
    always @* begin
        next_mode = mode_state;
        ctrl_we   = 1'b0;
        fail      = 1'b0;
        do_soft   = 1'b0;
        do_trig   = 1'b0;
        wdata     = cmd_data;
        // write only when access bit is set
        if (cmd_go && cmd_wr && !cidx[4]) begin
            if (cmd_addr == `SCP_ADDR_MODE_CTRL) begin
                case (cmd_data[7:6])
                    `SCP_MODE_SOFT_RST: begin
                        do_soft = 1'b1;
                    end
                    `SCP_MODE_NORMAL: begin
                        next_mode = S_NORMAL;
                        ctrl_we   = 1'b1;
                    end
                    `SCP_MODE_SLEEP: begin
                        if (mode_state == S_STOP) begin
                            fail      = 1'b1;
                            next_mode = S_RESTART;
                        end else if (mode_state == S_INIT) begin
                            fail      = 1'b1;
                            next_mode = S_NORMAL;
                        end else if (ctrl[`SCP_IDX_XCVR_A] == 8'h00 &&
                                     ctrl[`SCP_IDX_WAKE_B] == 8'h00) begin
                            fail      = 1'b1;
                            next_mode = S_RESTART;
                        end else begin
                            next_mode = S_SLEEP;
                            ctrl_we   = 1'b1;
                        end
                    end
                    default: begin
                        if (mode_state == S_INIT) begin
                            fail      = 1'b1;
                            next_mode = S_NORMAL;
                        end else begin
                            next_mode = S_STOP;
                            ctrl_we   = 1'b1;
                        end
                    end
                endcase
                if (mode_state != S_NORMAL)
                    wdata[4:3] = ctrl[`SCP_IDX_MODE][4:3];
                wdata[7:6] = mode_code(next_mode);
                wdata      = wdata & `SCP_MODE_CTRL_MASK;
            // stop allows a plain trigger only
            end else if (mode_state == S_STOP) begin
                if (cmd_addr == `SCP_ADDR_WDOG_CTRL &&
                    cmd_data == ctrl[`SCP_IDX_WDOG])
                    do_trig = 1'b1;
                else
                    fail = 1'b1;
            end else begin
                ctrl_we = 1'b1;
                do_trig = (cmd_addr == `SCP_ADDR_WDOG_CTRL);
            end
        end
        if (mode_state == S_SLEEP && wake_event)
            next_mode = S_RESTART;
        if (mode_state == S_RESTART && restart_done)
            next_mode = S_NORMAL;
        if (mode_state == S_FAILSAFE && failsafe_exit)
            next_mode = S_RESTART;
        if (failsafe_event)
            next_mode = S_FAILSAFE;
    end

    // serial frame engine
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            cs_d         <= 1'b1;
            clk_d        <= 1'b0;
            fcnt         <= 5'h00;
            rcnt         <= 5'h00;
            rx           <= 16'h0000;
            tx_sum       <= 8'h00;
            tx_dat       <= 8'h00;
            lvl_err      <= 1'b0;
            err_flag     <= 1'b0;
            frame_active <= 1'b0;
            spi_sdo_out  <= 1'b0;
        end else begin
            cs_d  <= cs_s;
            clk_d <= clk_s;
            if (cs_fall) begin
                frame_active <= 1'b1;
                fcnt         <= 5'h00;
                rcnt         <= 5'h00;
                lvl_err      <= clk_s;
                tx_sum       <= summary;
                spi_sdo_out  <= err_flag;
            end else if (cs_rise) begin
                frame_active <= 1'b0;
                spi_sdo_out  <= 1'b0;
                err_flag     <= frame_bad;
            end else begin
                if (clk_fall) begin
                    if (!fcnt[4])
                        rx[fcnt[3:0]] <= sdi_s;
                    // address complete, fetch data byte
                    if (fcnt == 5'h07)
                        tx_dat <= rd_val;
                    fcnt <= sat_inc(fcnt);
                end
                if (clk_rise) begin
                    if (rcnt[4])
                        spi_sdo_out <= 1'b0;
                    else if (rcnt[3])
                        spi_sdo_out <= tx_dat[rcnt[2:0]];
                    else
                        spi_sdo_out <= tx_sum[rcnt[2:0]];
                    rcnt <= sat_inc(rcnt);
                end
            end
        end
    end

    // register file and mode
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            for (i = 0; i < 10; i = i + 1)
                ctrl[i] <= `SCP_CTRL_RST;
            for (i = 0; i < 8; i = i + 1)
                stat[i] <= `SCP_STAT_RST;
            mode_state       <= S_INIT;
            soft_reset       <= 1'b0;
            watchdog_trigger <= 1'b0;
        end else begin
            soft_reset       <= do_soft;
            watchdog_trigger <= do_trig;
            // only explicit clears remove bits; set wins
            for (i = 0; i < 8; i = i + 1) begin
                if (cmd_go && cmd_wr && !sidx[3] && sidx[2:0] == i)
                    stat[i] <= st_set[i];
                else
                    stat[i] <= stat[i] | st_set[i];
            end
            if (fail)
                stat[`SCP_IDX_DEVICE_STATUS] <= stat[`SCP_IDX_DEVICE_STATUS] |
                                           st_set[`SCP_IDX_DEVICE_STATUS] |
                                           `SCP_SPI_FAIL_MASK;
            if (do_soft && !failsafe_event) begin
                for (i = 0; i < 10; i = i + 1)
                    ctrl[i] <= `SCP_CTRL_RST;
                mode_state <= S_INIT;
            end else begin
                if (ctrl_we)
                    ctrl[cidx[3:0]] <= wdata;
                if (next_mode != mode_state) begin
                    mode_state <= next_mode;
                    ctrl[`SCP_IDX_MODE][7:6] <= mode_code(next_mode);
                    // fail-safe output bits left as they are
                    if (next_mode == S_SLEEP) begin
                        ctrl[`SCP_IDX_XCVR_A] <= xcvr_sleep(ctrl[`SCP_IDX_XCVR_A]);
                        ctrl[`SCP_IDX_XCVR_B] <= xcvr_sleep(ctrl[`SCP_IDX_XCVR_B]);
                    end
                end
            end
        end
    end

endmodule // scp_command_port

// >>> hw/scp_defs.vh
`ifndef SCP_DEFS_VH
`define SCP_DEFS_VH

// control register addresses
`define SCP_ADDR_MODE_CTRL  7'h01
`define SCP_ADDR_HW_CFG     7'h02
`define SCP_ADDR_WDOG_CTRL  7'h03
`define SCP_ADDR_XCVR_A     7'h04
`define SCP_ADDR_XCVR_B     7'h05
`define SCP_ADDR_WAKE_A     7'h06
`define SCP_ADDR_WAKE_B     7'h07
`define SCP_ADDR_PULL_CTRL  7'h08
`define SCP_ADDR_TIMER_CTRL 7'h0C
`define SCP_ADDR_SCRATCH    7'h1E

// status register addresses
`define SCP_ADDR_SUP_STAT   7'h41
`define SCP_ADDR_THERMAL_STATUS 7'h42
`define SCP_ADDR_DEVICE_STATUS   7'h43
`define SCP_ADDR_XST_A      7'h44
`define SCP_ADDR_XST_B      7'h45
`define SCP_ADDR_WST_A      7'h46
`define SCP_ADDR_WST_B      7'h47
`define SCP_ADDR_WAKE_LVL   7'h48
`define SCP_ADDR_REG_STAT   7'h4C
`define SCP_ADDR_FAMILY_ID  7'h7E

// register array indices
`define SCP_IDX_MODE        4'h0
`define SCP_IDX_WDOG        4'h2
`define SCP_IDX_XCVR_A      4'h3
`define SCP_IDX_XCVR_B      4'h4
`define SCP_IDX_WAKE_B      4'h6
`define SCP_IDX_DEVICE_STATUS    3'h2

// frame and field layout
`define SCP_FRAME_BITS      5'h10
`define SCP_CTRL_RST        8'h00
`define SCP_STAT_RST        8'h00
`define SCP_MODE_CTRL_MASK  8'hDF
`define SCP_SPI_FAIL_MASK   8'h02
`define SCP_MODE_NORMAL     2'h0
`define SCP_MODE_SLEEP      2'h1
`define SCP_MODE_STOP       2'h2
`define SCP_MODE_SOFT_RST   2'h3
`define SCP_XCVR_ON         2'h3
`define SCP_XCVR_WAKE       2'h1
// arbitrary identification value
`define SCP_FAMILY_ID_VAL   8'h5A

`endif

// >>> hw/scp_sync.v
`timescale 1ns/100ps
module scp_sync #(
    parameter W = 4
) (
    input  wire         sys_clk,  // block clock
    input  wire         reset_n,  // synchronous reset, active low
    input  wire [W-1:0] async_in, // pins from outside the clock domain
    output reg  [W-1:0] sync_out  // second stage, safe to use
);

    reg [W-1:0] meta;

    always @(posedge sys_clk) begin
        if (!reset_n) begin
            meta     <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule // scp_sync
